// ==== hw/fcsl_params.svh ====
// Functional notes
// - Host toggles chip or output enable for every successive status read.
// - Host holds chip and output enable low, write enable and reset high for reads.
// - Status read is two cycles: write 70h, then read.
// - Host polls busy status by toggling output or chip enable.
// - Host gives an address inside the target block when confirming an erase.
// - Reset/power-down pin held low throughout any host reset.
`ifndef FCSL_PARAMS_SVH
`define FCSL_PARAMS_SVH

// wishbone register offsets (byte addresses)
`define FCSL_REG_CTRL      8'h00
`define FCSL_REG_ADDR      8'h04
`define FCSL_REG_WDATA     8'h08
`define FCSL_REG_RDATA     8'h0C
`define FCSL_REG_STATUS    8'h10

// control register fields
`define FCSL_CTRL_OP_LSB   0
`define FCSL_CTRL_GO_BIT   4
`define FCSL_CTRL_RPN_BIT  8

// host status register fields
`define FCSL_ST_BUSY_BIT   8
`define FCSL_ST_DONE_BIT   9

// flash command codes
`define FCSL_CMD_READ_ARRAY 8'hFF
`define FCSL_CMD_IDENTIFY   8'h90
`define FCSL_CMD_READ_STAT  8'h70
`define FCSL_CMD_CLR_STAT   8'h50
`define FCSL_CMD_PROGRAM    8'h40
`define FCSL_CMD_ERASE      8'h20
`define FCSL_CMD_CONFIRM    8'hD0
`define FCSL_CMD_SUSPEND    8'hB0
`define FCSL_CMD_RESUME     8'hD0

// status bit positions
`define FCSL_SR_READY      7
`define FCSL_SR_ERASE_SUSP 6
`define FCSL_SR_ERASE_ERR  5
`define FCSL_SR_PROG_ERR   4
`define FCSL_SR_SUPPLY     3
`define FCSL_SR_PROG_SUSP  2
`define FCSL_SR_LOCKED     1

// bus timing: setup/strobe and recovery times, ns
`define FCSL_T_STROBE_NS   100
`define FCSL_T_RECOVER_NS  30
`define FCSL_CLK_NS        10

// identify addresses
`define FCSL_ID_MAKER_ADDR  20'h0_0000
`define FCSL_ID_DEVICE_ADDR 20'h0_0001

`endif

// ==== hw/fcsl_pkg.sv ====
package fcsl_pkg;
    typedef enum logic [2:0] {
        FCSL_OP_WRITE = 3'h0,
        FCSL_OP_READ  = 3'h1,
        FCSL_OP_CMDRD = 3'h2,
        FCSL_OP_POLL  = 3'h3,
        FCSL_OP_CMD2W = 3'h4
    } fcsl_op_t;

    typedef enum logic [2:0] {
        FCSL_IDLE  = 3'b000,
        FCSL_SETUP = 3'b001,
        FCSL_PULSE = 3'b010,
        FCSL_HOLD  = 3'b011,
        FCSL_NEXT  = 3'b100
    } fcsl_state_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rp_n;
        logic [19:0] addr;
    } fcsl_pins_t;
endpackage

// ==== hw/fcsl_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// down-counter that flags when the loaded count has elapsed
module fcsl_timer #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              done_o
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else if (load_i)
            cnt_r <= count_i;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - W'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            done_o <= 1'b1;
        else if (load_i)
            done_o <= 1'b0;
        else
            done_o <= (cnt_r <= W'(1));
    end
endmodule // fcsl_timer
`default_nettype wire

// ==== hw/fcsl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcsl_params.svh"
module fcsl_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // flash pins
    output logic             ce_n_o,
    output logic             oe_n_o,
    output logic             we_n_o,
    output logic             reset_powerdown_n_o,
    output logic [19:0]      addr_o,
    input  wire logic [15:0] dq_i,
    output logic [15:0]      dq_o,
    output logic             dq_oe_o
);
    localparam int TW = 8;
    localparam int STROBE_CYC =
        (`FCSL_T_STROBE_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS;
    localparam int RECOV_CYC =
        (`FCSL_T_RECOVER_NS + `FCSL_CLK_NS - 1) / `FCSL_CLK_NS;

    fcsl_pkg::fcsl_state_t state_r;
    fcsl_pkg::fcsl_op_t    op_r;
    fcsl_pkg::fcsl_pins_t  pins_r;
    logic [19:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic [7:0]  status_r;
    logic        rpn_r;
    logic        phase_r;
    logic        done_r;
    logic        go;
    logic        t_load;
    logic [TW-1:0] t_cnt;
    logic        t_done;
    logic        busy;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign busy = (state_r != fcsl_pkg::FCSL_IDLE);
    assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                && hit(wb_adr_i, `FCSL_REG_CTRL) && wb_dat_i[`FCSL_CTRL_GO_BIT]
                && !busy && rpn_r;

    // ----------------------------------------------------------------
    // wishbone slave: one-cycle ack, unmapped reads return zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_r  <= '0;
            wdata_r <= '0;
            rpn_r   <= 1'b0;
            op_r    <= fcsl_pkg::FCSL_OP_WRITE;
        end
        else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o)
        begin
            if (hit(wb_adr_i, `FCSL_REG_ADDR) && !busy)
                addr_r <= wb_dat_i[19:0];
            if (hit(wb_adr_i, `FCSL_REG_WDATA) && !busy)
                wdata_r <= wb_dat_i[15:0];
            if (hit(wb_adr_i, `FCSL_REG_CTRL) && wb_sel_i[1] && !busy)
                rpn_r <= wb_dat_i[`FCSL_CTRL_RPN_BIT];
            if (go)
                op_r <= fcsl_pkg::fcsl_op_t'(wb_dat_i[`FCSL_CTRL_OP_LSB +: 3]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
        begin
            case (wb_adr_i)
                `FCSL_REG_CTRL:   wb_dat_o <= {23'h0, rpn_r, 8'h00};
                `FCSL_REG_ADDR:   wb_dat_o <= {12'h000, addr_r};
                `FCSL_REG_WDATA:  wb_dat_o <= {16'h0000, wdata_r};
                `FCSL_REG_RDATA:  wb_dat_o <= {16'h0000, rdata_r};
                `FCSL_REG_STATUS: wb_dat_o <= {22'h0, done_r, busy, status_r};
                default:          wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // flash bus cycle sequencer
    // ----------------------------------------------------------------
    fcsl_timer #(.W(TW)) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (t_load),
        .count_i (t_cnt),
        .done_o  (t_done)
    );

    always_comb
    begin
        t_load = 1'b0;
        t_cnt  = TW'(STROBE_CYC);
        case (state_r)
            fcsl_pkg::FCSL_IDLE:  t_load = go;
            fcsl_pkg::FCSL_SETUP: t_load = 1'b1;
            fcsl_pkg::FCSL_PULSE:
            begin
                t_load = t_done;
                t_cnt  = TW'(RECOV_CYC);
            end
            default: t_load = 1'b0;
        endcase
    end

    // two-cycle ops: first a command write, second a read or write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= fcsl_pkg::FCSL_IDLE;
            phase_r <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            case (state_r)
                fcsl_pkg::FCSL_IDLE:
                    if (go)
                    begin
                        state_r <= fcsl_pkg::FCSL_SETUP;
                        phase_r <= 1'b0;
                        done_r  <= 1'b0;
                    end
                fcsl_pkg::FCSL_SETUP: state_r <= fcsl_pkg::FCSL_PULSE;
                fcsl_pkg::FCSL_PULSE:
                    if (t_done)
                        state_r <= fcsl_pkg::FCSL_HOLD;
                fcsl_pkg::FCSL_HOLD:
                    if (t_done)
                        state_r <= fcsl_pkg::FCSL_NEXT;
                fcsl_pkg::FCSL_NEXT:
                    if (!phase_r && (op_r != fcsl_pkg::FCSL_OP_WRITE)
                        && (op_r != fcsl_pkg::FCSL_OP_READ))
                    begin
                        phase_r <= 1'b1;
                        state_r <= fcsl_pkg::FCSL_SETUP;
                    end
                    else if (op_r == fcsl_pkg::FCSL_OP_POLL
                             && !status_r[`FCSL_SR_READY])
                        state_r <= fcsl_pkg::FCSL_SETUP;
                    else
                    begin
                        state_r <= fcsl_pkg::FCSL_IDLE;
                        done_r  <= 1'b1;
                    end
                default: state_r <= fcsl_pkg::FCSL_IDLE;
            endcase
        end
    end

    // read in this pass, or write
    logic rd_pass;
    always_comb
    begin
        case (op_r)
            fcsl_pkg::FCSL_OP_READ:  rd_pass = 1'b1;
            fcsl_pkg::FCSL_OP_CMDRD: rd_pass = phase_r;
            fcsl_pkg::FCSL_OP_POLL:  rd_pass = phase_r;
            default:                 rd_pass = 1'b0;
        endcase
    end

    // pins: strobes drop in PULSE, rise before HOLD so each read toggles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pins_r  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b0,
                         addr: 20'h0_0000};
            dq_o    <= '0;
            dq_oe_o <= 1'b0;
        end
        else
        begin
            pins_r.rp_n <= rpn_r;
            pins_r.addr <= addr_r;
            if (state_r == fcsl_pkg::FCSL_SETUP)
            begin
                dq_oe_o <= !rd_pass;
                dq_o    <= (phase_r || op_r == fcsl_pkg::FCSL_OP_WRITE)
                           ? wdata_r : {8'h00, wdata_r[7:0]};
            end
            else if (state_r == fcsl_pkg::FCSL_IDLE)
                dq_oe_o <= 1'b0;
            if (state_r == fcsl_pkg::FCSL_SETUP || (state_r == fcsl_pkg::FCSL_PULSE
                && !t_done))
            begin
                pins_r.ce_n <= 1'b0;
                pins_r.oe_n <= !rd_pass;
                pins_r.we_n <= rd_pass;
            end
            else
            begin
                pins_r.ce_n <= 1'b1;
                pins_r.oe_n <= 1'b1;
                pins_r.we_n <= 1'b1;
            end
        end
    end

    assign ce_n_o              = pins_r.ce_n;
    assign oe_n_o              = pins_r.oe_n;
    assign we_n_o              = pins_r.we_n;
    assign reset_powerdown_n_o = pins_r.rp_n;
    assign addr_o              = pins_r.addr;

    // sample data at the end of the strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_r  <= '0;
            status_r <= '0;
        end
        else if (state_r == fcsl_pkg::FCSL_PULSE && t_done && rd_pass)
        begin
            rdata_r <= dq_i;
            if (op_r == fcsl_pkg::FCSL_OP_POLL)
                status_r <= {dq_i[7:1], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_toggle;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == fcsl_pkg::FCSL_HOLD) |=> ce_n_o;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("chip enable not toggled");

    property p_read_levels;
        @(posedge clk_i) disable iff (rst_i)
        (!oe_n_o) |-> (!ce_n_o && we_n_o && reset_powerdown_n_o);
    endproperty
    a_read_levels: assert property (p_read_levels)
        else $error("bad read pin levels");

    property p_no_drive_read;
        @(posedge clk_i) disable iff (rst_i)
        (!oe_n_o) |-> !dq_oe_o;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read)
        else $error("driving bus during read");

    property p_resv;
        @(posedge clk_i) disable iff (rst_i) status_r[0] == 1'b0;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved status bit set");

    sequence s_go;
        go;
    endsequence
    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        s_go |=> ##1 !ce_n_o;
    endproperty
    a_start: assert property (p_start)
        else $error("cycle did not start");

    property p_rp_hold;
        @(posedge clk_i) disable iff (rst_i)
        !rpn_r |=> !reset_powerdown_n_o;
    endproperty
    a_rp_hold: assert property (p_rp_hold)
        else $error("reset pin not held");

    property p_strobe_len;
        @(posedge clk_i) disable iff (rst_i)
        $fell(ce_n_o) |-> !ce_n_o [*8];
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe too short");

    property p_poll_done;
        @(posedge clk_i) disable iff (rst_i)
        $rose(done_r) && op_r == fcsl_pkg::FCSL_OP_POLL |-> status_r[7];
    endproperty
    a_poll_done: assert property (p_poll_done)
        else $error("poll ended while busy");
endmodule // fcsl_host
`default_nettype wire

// ==== bench/fcsl_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// flash device model: decoder, engine, status
// ------------------------------------------------
module fcsl_flash_model #(
    parameter logic [15:0] MAKER_CODE  = 16'h1A2B, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h3C4D, // arbitrary value
    parameter int          BUSY_CYC    = 400
) (
    input  wire logic        clk_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        rp_n_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        vpp_low_i,
    input  wire logic        wp_n_i,
    input  wire logic        fail_i,
    output logic      [15:0] dq_o
);
    logic [7:0]  sr;
    logic [15:0] out = 16'h0000;
    logic [15:0] d_q;
    logic [19:0] a_q;
    logic [1:0]  mode;
    logic [1:0]  pend;
    logic [1:0]  op;
    logic        wr_q;
    logic        rd_q;
    logic        susp;
    int          busy;
    wire         wr_act = !ce_n_i && !we_n_i;
    wire         rd_act = !ce_n_i && !oe_n_i && we_n_i && rp_n_i;
    // released bus shows the inverse of the last value
    assign dq_o = rd_act ? out : ~out;
    always @(posedge clk_i)
    begin
        wr_q <= wr_act;
        rd_q <= rd_act;
        if (wr_act)
        begin
            a_q <= addr_i;
            d_q <= dq_i;
        end
        if (!rp_n_i)
        begin
            mode <= 2'd0;
            pend <= 2'd0;
            busy <= 0;
            susp <= 1'b0;
            sr   <= 8'h80;
        end
        else
        begin
            if (busy > 0 && !susp)
            begin
                busy <= busy - 1;
                if (busy == 1)
                begin
                    sr[7] <= 1'b1;
                    sr[op == 2'd2 ? 5 : 4] <= fail_i;
                end
            end
            if (rd_act && !rd_q)
                out <= mode == 2'd2 ? {8'h00, sr[7:1], 1'b0} :
                       mode == 2'd1 ? (addr_i == 20'h0_0000 ? MAKER_CODE :
                                       addr_i == 20'h0_0001 ? DEVICE_CODE : 16'h0000) :
                       addr_i[15:0] ^ 16'h3C3C;
            if (wr_q && !wr_act)
            begin
                if (pend != 2'd0)
                begin
                    pend <= 2'd0;
                    mode <= 2'd2;
                    if (vpp_low_i)
                        sr[3] <= 1'b1;
                    else if (!wp_n_i && a_q[19:15] == 5'h00)
                        sr[1] <= 1'b1;
                    else
                    begin
                        busy  <= BUSY_CYC;
                        op    <= pend;
                        sr[7] <= 1'b0;
                    end
                end
                else if (busy > 0 && !susp)
                begin
                    if (d_q[7:0] == 8'hB0)
                    begin
                        susp  <= 1'b1;
                        sr[7] <= 1'b1;
                        sr[op == 2'd1 ? 2 : 6] <= 1'b1;
                    end
                end
                else if (susp && d_q[7:0] == 8'hD0)
                begin
                    susp  <= 1'b0;
                    sr[7] <= 1'b0;
                    sr[6] <= 1'b0;
                    sr[2] <= 1'b0;
                    mode  <= 2'd2;
                end
                else
                    case (d_q[7:0])
                        8'hFF: mode <= 2'd0;
                        8'h90: mode <= 2'd1;
                        8'h70: mode <= 2'd2;
                        8'h50:
                        begin
                            sr[5:3] <= 3'b000;
                            sr[1]   <= 1'b0;
                            mode    <= 2'd0;
                        end
                        8'h40, 8'h10: pend <= 2'd1;
                        8'h20: pend <= 2'd2;
                        default: ;
                    endcase
            end
        end
    end
endmodule // fcsl_flash_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcsl_params.svh"
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] %0t got %h expected %h", $time, g, e); \
        end \
    end
module tb;
    localparam logic [15:0] MAKER  = 16'h1A2B; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h3C4D; // arbitrary value
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack, ce_n, oe_n, we_n, rpn, dq_oe;
    logic        vpp_low = 1'b0;
    logic        wp_n = 1'b1;
    logic        fail = 1'b0;
    logic [19:0] faddr;
    logic [15:0] host_dq, flash_dq;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;
    wire  [15:0] dq_bus = dq_oe ? host_dq : flash_dq;

    fcsl_host fcsl_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
        .reset_powerdown_n_o(rpn), .addr_o(faddr), .dq_i(dq_bus), .dq_o(host_dq),
        .dq_oe_o(dq_oe));
    fcsl_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .BUSY_CYC(400))
        fcsl_flash_model_i (.clk_i(clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .rp_n_i(rpn), .addr_i(faddr), .dq_i(dq_bus), .vpp_low_i(vpp_low), .wp_n_i(wp_n),
        .fail_i(fail), .dq_o(flash_dq));

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------
    // bus and flash access tasks
    // ------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'hF;
        adr  <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 100);
        if (ack !== 1'b1)
        begin
            n_mismatch++;
            $display("[FAIL] %0t no bus acknowledge", $time);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic flash(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d,
                         output logic [31:0] r);
        logic [31:0] s;
        int n;
        wb(1'b1, `FCSL_REG_ADDR, {12'h000, a}, s);
        wb(1'b1, `FCSL_REG_WDATA, {16'h0000, d}, s);
        wb(1'b1, `FCSL_REG_CTRL, 32'h0000_0110 | {29'h0, op}, s);
        n = 0;
        do
        begin
            wb(1'b0, `FCSL_REG_STATUS, 32'h0000_0000, s);
            n++;
        end
        while (s[`FCSL_ST_BUSY_BIT] !== 1'b0 && n < 3000);
        if (s[`FCSL_ST_BUSY_BIT] !== 1'b0)
        begin
            n_mismatch++;
            $display("[FAIL] %0t flash cycle stuck busy", $time);
        end
        wb(1'b0, `FCSL_REG_RDATA, 32'h0000_0000, r);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        `CHK(rpn, 1'b0)
        wb(1'b1, `FCSL_REG_CTRL, 32'h0000_0100, q);
        wb(1'b0, 8'h20, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
    endtask

    task automatic t_reads();
        flash(3'h1, 20'h1_2345, 16'h0000, q);
        `CHK(q[15:0], 16'h2345 ^ 16'h3C3C)
        flash(3'h2, 20'h0_0000, 16'h0090, q);
        `CHK(q[15:0], MAKER)
        flash(3'h2, 20'h0_0001, 16'h0090, q);
        `CHK(q[15:0], DEVICE)
        flash(3'h2, 20'h0_0007, 16'h0070, q);
        `CHK(q[15:0], 16'h0080)
        flash(3'h3, 20'h0_0007, 16'h0070, q);
        wb(1'b0, `FCSL_REG_STATUS, 32'h0000_0000, q);
        `CHK(q[7:0], 8'h80)
        `CHK(q[9:8], 2'b10)
    endtask

    task automatic t_op(input logic [7:0] setup, input logic [19:0] a, input logic vl,
                        input logic wp, input logic fl, input logic [7:0] exp);
        vpp_low <= vl;
        wp_n    <= wp;
        fail    <= fl;
        if (setup == 8'h40)
            flash(3'h4, a, 16'h0040, q);
        else
        begin
            flash(3'h0, a, {8'h00, setup}, q);
            flash(3'h0, a, 16'h00D0, q);
        end
        flash(3'h3, a, 16'h0070, q);
        `CHK(q[7:0], exp)
        flash(3'h1, 20'h0_0123, 16'h0000, q);
        `CHK(q[15:0], {8'h00, exp})
        flash(3'h0, a, 16'h0050, q);
        flash(3'h1, 20'h0_0123, 16'h0000, q);
        `CHK(q[15:0], 16'h0123 ^ 16'h3C3C)
        flash(3'h2, a, 16'h0070, q);
        `CHK(q[15:0], 16'h0080)
    endtask

    task automatic t_suspend(input logic [7:0] setup, input logic [7:0] bit_set);
        flash(3'h0, 20'h0_8000, {8'h00, setup}, q);
        flash(3'h0, 20'h0_8000, 16'h00D0, q);
        flash(3'h0, 20'h0_0000, 16'h00FF, q);
        flash(3'h1, 20'h0_8001, 16'h0000, q);
        `CHK(q[7], 1'b0)
        flash(3'h0, 20'h0_0000, 16'h00B0, q);
        flash(3'h2, 20'h0_0000, 16'h0070, q);
        `CHK(q[7:0], 8'h80 | bit_set)
        flash(3'h0, 20'h0_0000, 16'h00D0, q);
        flash(3'h3, 20'h0_0000, 16'h0070, q);
        `CHK(q[7:0], 8'h80)
    endtask

    task automatic t_powerdown();
        fail <= 1'b1;
        flash(3'h0, 20'h0_8000, 16'h0040, q);
        flash(3'h0, 20'h0_8000, 16'h00D0, q);
        wb(1'b1, `FCSL_REG_CTRL, 32'h0000_0000, q);
        wb(1'b0, `FCSL_REG_STATUS, 32'h0000_0000, q);
        `CHK(rpn, 1'b0)
        wb(1'b1, `FCSL_REG_CTRL, 32'h0000_0100, q);
        fail <= 1'b0;
        flash(3'h2, 20'h0_0000, 16'h0070, q);
        `CHK(q[15:0], 16'h0080)
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_reads();
        t_op(8'h40, 20'h0_8000, 1'b0, 1'b1, 1'b0, 8'h80);
        t_op(8'h40, 20'h0_8000, 1'b0, 1'b1, 1'b1, 8'h90);
        t_op(8'h20, 20'h0_8000, 1'b0, 1'b1, 1'b1, 8'hA0);
        t_op(8'h20, 20'h0_8000, 1'b0, 1'b1, 1'b0, 8'h80);
        t_op(8'h40, 20'h0_8000, 1'b1, 1'b1, 1'b0, 8'h88);
        t_op(8'h20, 20'h0_0010, 1'b0, 1'b0, 1'b0, 8'h82);
        t_op(8'h20, 20'h0_8000, 1'b0, 1'b0, 1'b0, 8'h80);
        t_suspend(8'h20, 8'h40);
        t_suspend(8'h40, 8'h04);
        t_powerdown();
        test_done();
    end
endmodule // tb
`default_nettype wire
